// *** hdl/core_timer.sv ***
// Purpose: core timer chain, periodic tick, watchdog and reset sequencing
// Assumes: CLK_IN is the bus clock E; inputs synchronous to CLK_IN
// Notes: RST_B_IN stands for the power-on reset
// Functional notes
// - bus clock div four drives 8-bit counter
// - counter wrap FF to 00 sets overflow flag
// - overflow flag read-only, cleared by clear bit
// - one stage more gives E/2048 tick base
// - rate select picks 2^11..2^14 tap
// - tick flag sets on selected tap, clear-bit only
// - overflow enable requests interrupt while flag set
// - tick enable requests interrupt while flag set
// - clear bits act on one, read zero
// - reset sets rate select to 11
// - watchdog divides tick by eight, then resets
// - zero to bit 0 at 3FF0 refreshes
// - timeout drives reset pin low three cycles
// - every chip reset clears whole counter chain
// - power-on holds 4064 cycles, then clears chain
// - stop with stop disabled causes internal reset
// - watchdog is a fixed option, runs in wait
// - timer keeps counting and wakes from wait
// - count register reads live counter, no side effect
//
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps

module core_timer #(
    parameter bit WATCHDOG_ON = 1'b1, // fixed option: watchdog present
    parameter bit STOP_OFF = 1'b0 // fixed option: stop instruction disabled
) (
    input wire logic CLK_IN,
    input wire logic RST_B_IN,
    input wire logic [15:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic STOP_EXEC_IN,
    input wire logic WAIT_IN,
    input wire logic RESET_PIN_IN,
    output logic [7:0] RDATA_OUT,
    output logic IRQ_OUT,
    output logic WAKE_OUT,
    output logic CHIP_RESET_OUT,
    output logic RESET_PIN_OUT,
    output logic RESET_PIN_OE_OUT
);
    import core_timer_pkg::*;

    // ==============================
    // declarations
    logic [CHAIN_W-1:0] chain; // whole ripple chain, bit 0 is E/2
    logic [CHAIN_W-1:0] next_chain; // chain after this edge
    control_s ctrl; // enables and rate select
    logic ovf_flag; // counter wrapped
    logic tick_flag; // selected tap went active
    logic [2:0] dog; // final divide-by-eight of the watchdog
    logic [11:0] por_cnt; // power-on delay counter
    logic [1:0] pin_cnt; // reset pin low counter
    rst_state_e state; // reset sequencer state
    rst_state_e next_state; // sequencer state after this edge
    logic chain_clr; // any chip reset clears the chain
    logic ovf_evt; // counter wraps this edge
    logic tick_evt; // selected tap wraps this edge
    logic dog_evt; // watchdog times out this edge
    logic int_reset; // internal reset request
    logic wr_sc; // write to status/control
    logic rd_hit; // read of a mapped register
    logic [7:0] rd_mux; // read data before the output flop
    logic sys_rst; // synchronous reset of the software state

    // ==============================
    // functions
    // tap decode of the selected rate, used for the tick event only
    function automatic logic tap_wrap(input logic [CHAIN_W-1:0] c,
                                      input logic [1:0] r);
        logic hit;
        hit = 1'b0;
        case (r)
            2'h0: hit = &c[TICK_BASE:0];
            2'h1: hit = &c[TICK_BASE+1:0];
            2'h2: hit = &c[TICK_BASE+2:0];
            2'h3: hit = &c[TICK_BASE+3:0];
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    // address compare shared by the read and write paths
    function automatic logic addr_is(input logic [15:0] a,
                                     input logic [15:0] b);
        return a == b;
    endfunction

    // ==============================
    // chain events
    // overflow when prescaler and counter are all ones
    assign ovf_evt = &chain[OVF_TOP:0];
    // tick base is E/2048, three more stages give the taps
    assign tick_evt = tap_wrap(chain, ctrl.rate);
    // watchdog fires on the eighth tick after its last clear
    assign dog_evt = WATCHDOG_ON && tick_evt && (dog == WATCHDOG_LAST);
    // stop while the option disables stop acts as a reset
    assign int_reset = dog_evt || (STOP_OFF && STOP_EXEC_IN);

    // chip reset from any source clears the chain
    assign chain_clr = (state != ST_RUN) || !RESET_PIN_IN;
    // software state also resets while in any reset
    assign sys_rst = chain_clr;

    // ==============================
    // bus decode
    assign wr_sc = WR_IN && addr_is(ADDR_IN, STATUS_CONTROL_ADDR);
    assign rd_hit = RD_IN && (addr_is(ADDR_IN, STATUS_CONTROL_ADDR)
                    || addr_is(ADDR_IN, COUNT_ADDR));

    // ==============================
    // reset sequencer
    // next state of the power-on and pin sequencing
    always_comb begin
        next_state = state;
        case (state)
            ST_POR: begin
                // leave only after the full power-on delay
                if (por_cnt == POR_CYCLES - 12'h001) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                // internal reset pulls the pin low
                if (int_reset) begin
                    next_state = ST_PIN;
                end
            end
            ST_PIN: begin
                // hold the pin for the minimum low time
                if (pin_cnt == PIN_LOW_CYCLES - 2'h1) begin
                    next_state = ST_RUN;
                end
            end
            default: begin
                next_state = ST_POR;
            end
        endcase
    end

    // state register
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            state <= ST_POR;
        end else begin
            state <= next_state;
        end
    end

    // power-on delay counter; chain counts freely meanwhile
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            por_cnt <= 12'h000;
        end else if (state == ST_POR) begin
            por_cnt <= por_cnt + 12'h001;
        end else begin
            por_cnt <= 12'h000;
        end
    end

    // pin low counter
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            pin_cnt <= 2'h0;
        end else if (state == ST_PIN) begin
            pin_cnt <= pin_cnt + 2'h1;
        end else begin
            pin_cnt <= 2'h0;
        end
    end

    // ==============================
    // counter chain
    // power-on counts, the release clears once more
    always_comb begin
        next_chain = chain + CHAIN_W'(1);
        if (state == ST_POR) begin
            // power-on runs the chain but clears it at release
            if (next_state != ST_POR) begin
                next_chain = '0;
            end
        end else if (chain_clr) begin
            next_chain = '0;
        end
    end

    // chain flops; no wait gating, the timer runs in wait
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            chain <= '0;
        end else begin
            chain <= next_chain;
        end
    end

    // ==============================
    // watchdog
    // only the final stage clears on refresh, so the timeout
    // depends on where in the tick period software refreshes
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            dog <= 3'h0;
        end else if (sys_rst || !WATCHDOG_ON) begin
            dog <= 3'h0;
        end else if (WR_IN && addr_is(ADDR_IN, WATCHDOG_ADDR)
                     && !WDATA_IN[0]) begin
            dog <= 3'h0;
        end else if (tick_evt) begin
            dog <= dog + 3'h1;
        end
    end

    // ==============================
    // control register
    // enables and rate; rate changes near a tap edge can drop
    // or add a tick, software refreshes the watchdog first
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            ctrl <= '{ovf_ie: 1'b0, tick_ie: 1'b0, rate: RATE_RESET};
        end else if (sys_rst) begin
            ctrl <= '{ovf_ie: 1'b0, tick_ie: 1'b0, rate: RATE_RESET};
        end else if (wr_sc) begin
            ctrl.ovf_ie <= WDATA_IN[OVF_IE_BIT];
            ctrl.tick_ie <= WDATA_IN[TICK_IE_BIT];
            ctrl.rate <= {WDATA_IN[RATE_HI_BIT], WDATA_IN[RATE_LO_BIT]};
        end
    end

    // ==============================
    // flags
    // overflow flag: writes to the flag bit are ignored, set wins
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            ovf_flag <= 1'b0;
        end else if (sys_rst) begin
            ovf_flag <= 1'b0;
        end else if (ovf_evt) begin
            ovf_flag <= 1'b1;
        end else if (wr_sc && WDATA_IN[OVF_CLR_BIT]) begin
            ovf_flag <= 1'b0;
        end
    end

    // tick flag: same scheme as the overflow flag
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            tick_flag <= 1'b0;
        end else if (sys_rst) begin
            tick_flag <= 1'b0;
        end else if (tick_evt) begin
            tick_flag <= 1'b1;
        end else if (wr_sc && WDATA_IN[TICK_CLR_BIT]) begin
            tick_flag <= 1'b0;
        end
    end

    // ==============================
    // read path
    // clear bits read zero; count read has no side effect
    always_comb begin
        rd_mux = 8'h00;
        if (addr_is(ADDR_IN, STATUS_CONTROL_ADDR)) begin
            rd_mux[OVF_FLAG_BIT] = ovf_flag;
            rd_mux[TICK_FLAG_BIT] = tick_flag;
            rd_mux[OVF_IE_BIT] = ctrl.ovf_ie;
            rd_mux[TICK_IE_BIT] = ctrl.tick_ie;
            rd_mux[RATE_HI_BIT] = ctrl.rate[1];
            rd_mux[RATE_LO_BIT] = ctrl.rate[0];
        end else if (addr_is(ADDR_IN, COUNT_ADDR)) begin
            rd_mux = chain[PRESCALE_W +: COUNT_W];
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            RDATA_OUT <= 8'h00;
        end else if (rd_hit) begin
            RDATA_OUT <= rd_mux;
        end else begin
            RDATA_OUT <= 8'h00;
        end
    end

    // ==============================
    // interrupt and wake
    // level request while an enabled flag stands; dropped at once
    // when any reset starts, on the same edge that clears the flags
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            IRQ_OUT <= 1'b0;
        end else begin
            IRQ_OUT <= !sys_rst && ((ovf_flag && ctrl.ovf_ie)
                       || (tick_flag && ctrl.tick_ie));
        end
    end

    // wake only matters while the cpu waits
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            WAKE_OUT <= 1'b0;
        end else begin
            WAKE_OUT <= WAIT_IN && !sys_rst && ((ovf_flag && ctrl.ovf_ie)
                        || (tick_flag && ctrl.tick_ie));
        end
    end

    // ==============================
    // reset outputs
    // chip reset covers power-on, pin and internal sources
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            CHIP_RESET_OUT <= 1'b1;
        end else begin
            CHIP_RESET_OUT <= (next_state != ST_RUN) || !RESET_PIN_IN;
        end
    end

    // open-drain pin: drive low only while the pin stage runs
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            RESET_PIN_OE_OUT <= 1'b0;
        end else begin
            RESET_PIN_OE_OUT <= (next_state == ST_PIN);
        end
    end

    // the pin value is always low; only the enable moves
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            RESET_PIN_OUT <= 1'b0;
        end else begin
            RESET_PIN_OUT <= 1'b0;
        end
    end

endmodule

// *** inc/core_timer_pkg.sv ***
// Purpose: shared constants and types of the core timer block
// Assumes: CLK_IN is the internal bus clock E
// Notes: offsets are byte addresses on the 16-bit register port
package core_timer_pkg;

    // ==============================
    // register map
    localparam logic [15:0] STATUS_CONTROL_ADDR = 16'h0008; // status/control
    localparam logic [15:0] COUNT_ADDR = 16'h0009; // live ripple count
    localparam logic [15:0] WATCHDOG_ADDR = 16'h3ff0; // refresh location

    // ==============================
    // status/control field positions
    localparam int OVF_FLAG_BIT = 7;
    localparam int TICK_FLAG_BIT = 6;
    localparam int OVF_IE_BIT = 5;
    localparam int TICK_IE_BIT = 4;
    localparam int OVF_CLR_BIT = 3;
    localparam int TICK_CLR_BIT = 2;
    localparam int RATE_HI_BIT = 1;
    localparam int RATE_LO_BIT = 0;

    // ==============================
    // reset values and chain layout
    localparam logic [1:0] RATE_RESET = 2'h3; // slowest tick rate
    localparam int CHAIN_W = 14; // 2^14 bus clocks is the slowest tap
    localparam int PRESCALE_W = 2; // divide by four ahead of the counter
    localparam int COUNT_W = 8; // readable ripple counter
    localparam int OVF_TOP = 9; // chain bits 0..9 give E/1024
    localparam int TICK_BASE = 10; // chain bits 0..10 give E/2048
    localparam logic [2:0] WATCHDOG_LAST = 3'h7; // eighth tick times out

    // ==============================
    // timing in bus clock cycles
    localparam logic [11:0] POR_CYCLES = 12'hfe0; // 4064 cycles
    localparam int PIN_LOW_MIN = 3; // reset pin low time, E clocks
    localparam logic [1:0] PIN_LOW_CYCLES = 2'(PIN_LOW_MIN);

    // ==============================
    // software-visible control fields
    typedef struct packed {
        logic ovf_ie; // overflow interrupt enable
        logic tick_ie; // periodic interrupt enable
        logic [1:0] rate; // tick rate select
    } control_s;

    // reset sequencing states
    typedef enum logic [1:0] {
        ST_POR = 2'b00, // power-on delay running
        ST_RUN = 2'b01, // normal operation
        ST_PIN = 2'b10 // driving the reset pin low
    } rst_state_e;

endpackage

// *** verification/cpu_bus_model.sv ***
// Purpose: cpu side of the register port
// Assumes: one-cycle strobes, driven just after a rising edge
// Notes: idle address and data show the inverse of the last value
`timescale 1ns/10ps
module cpu_bus_model
    import core_timer_pkg::*;
(
    input wire logic clk_in,
    output logic [15:0] addr_out,
    output logic [7:0] wdata_out,
    output logic wr_out,
    output logic rd_out
);
    // ====
    // one bus cycle; a stale bus would hide decode faults
    initial begin
        addr_out = 16'h0000;
        wdata_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    task automatic cycle(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= w;
        rd_out <= !w;
        @(posedge clk_in);
        addr_out <= ~a; // released: inverse of last value
        wdata_out <= ~d;
        wr_out <= 1'b0;
        rd_out <= 1'b0;
    endtask
    // refresh first, then a new tap; a lost or extra tick then cannot time out the watchdog
    task automatic set_ctl(input logic [7:0] d);
        cycle(1'b1, WATCHDOG_ADDR, 8'h00);
        cycle(1'b1, STATUS_CONTROL_ADDR, d);
    endtask
endmodule

// *** verification/core_timer_chk.sv ***
// Purpose: port-level checks of the core timer
// Assumes: single clock domain, async active-low reset
// Notes: attached by bind at the foot of this file
`timescale 1ns/10ps
module core_timer_chk
    import core_timer_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RST_B_IN,
    input wire logic [15:0] ADDR_IN,
    input wire logic RD_IN,
    input wire logic WAIT_IN,
    input wire logic RESET_PIN_IN,
    input wire logic [7:0] RDATA_OUT,
    input wire logic IRQ_OUT,
    input wire logic WAKE_OUT,
    input wire logic CHIP_RESET_OUT,
    input wire logic RESET_PIN_OUT,
    input wire logic RESET_PIN_OE_OUT
);
    // ====
    // edges since power-on release, saturating
    logic [11:0] por_cnt;
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            por_cnt <= 12'h000;
        end else if (por_cnt != 12'hfff) begin
            por_cnt <= por_cnt + 12'h001;
        end
    end
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RST_B_IN);
    sequence pin_pulse_s;
        RESET_PIN_OE_OUT [*3];
    endsequence
    // ====
    // assertions
    rdata_idle_a: assert property (!$past(RD_IN) |-> RDATA_OUT == 8'h00)
        else $error("read data outside read slot");
    clear_bits_a: assert property ($past(RD_IN) && $past(ADDR_IN) == STATUS_CONTROL_ADDR
        |-> RDATA_OUT[3:2] == 2'b00) else $error("clear bits read one");
    por_hold_a: assert property (por_cnt < POR_CYCLES |-> CHIP_RESET_OUT)
        else $error("chip reset left early");
    por_end_a: assert property ($fell(CHIP_RESET_OUT) && por_cnt != 12'hfff
        |-> por_cnt == POR_CYCLES) else $error("power-on length wrong");
    pin_drive_a: assert property (RESET_PIN_OUT == 1'b0)
        else $error("reset pin driven high");
    pin_pulse_a: assert property ($rose(RESET_PIN_OE_OUT) |-> pin_pulse_s)
        else $error("reset pin pulse short");
    pin_reset_a: assert property (RESET_PIN_OE_OUT |-> CHIP_RESET_OUT)
        else $error("pin low without chip reset");
    ext_reset_a: assert property (!RESET_PIN_IN |=> CHIP_RESET_OUT)
        else $error("pin reset ignored");
    wake_cause_a: assert property (WAKE_OUT |-> $past(WAIT_IN)
        && (IRQ_OUT || $past(IRQ_OUT))) else $error("wake without cause");
    irq_quiet_a: assert property (CHIP_RESET_OUT && $past(CHIP_RESET_OUT)
        |-> !IRQ_OUT) else $error("interrupt during reset");
endmodule
bind core_timer core_timer_chk i_chk (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .ADDR_IN(ADDR_IN),
    .RD_IN(RD_IN), .WAIT_IN(WAIT_IN), .RESET_PIN_IN(RESET_PIN_IN), .RDATA_OUT(RDATA_OUT),
    .IRQ_OUT(IRQ_OUT), .WAKE_OUT(WAKE_OUT), .CHIP_RESET_OUT(CHIP_RESET_OUT),
    .RESET_PIN_OUT(RESET_PIN_OUT), .RESET_PIN_OE_OUT(RESET_PIN_OE_OUT));

// *** verification/core_timer_rti_watchdog_bench.sv ***
// Purpose: self-checking bench of the core timer
// Assumes: 25 MHz clock, stop option disabled, watchdog present
// Notes: reference model stops after any reset it cannot follow
`timescale 1ns/10ps
module core_timer_rti_watchdog_bench;
    import core_timer_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic stop_x = 1'b0;
    logic wait_x = 1'b0;
    logic ext_hi = 1'b1; // outside reset source, high = idle
    logic [15:0] addr;
    logic [7:0] wdata, rdata;
    logic wr, rd, irq, wake, crst, pin_o, pin_oe, pin_lvl;
    int fail_count = 0;
    int n_compared = 0;
    int chain, por, rdq, k;
    bit live = 1'b1; // model in step with the design
    bit ovf, tck, oie, tie, to_due, hit_o, hit_t, irq_m, irq_m1, wake_m;
    bit [1:0] rate;
    bit [2:0] dog;
    // pulled-up pin: low when the block or the outside drives it
    assign pin_lvl = ext_hi && !(pin_oe && !pin_o);
    initial forever #20 clk = ~clk;
    core_timer #(.WATCHDOG_ON(1'b1), .STOP_OFF(1'b1)) i_core_timer (
        .CLK_IN(clk), .RST_B_IN(rst_b), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
        .RD_IN(rd), .STOP_EXEC_IN(stop_x), .WAIT_IN(wait_x), .RESET_PIN_IN(pin_lvl),
        .RDATA_OUT(rdata), .IRQ_OUT(irq), .WAKE_OUT(wake), .CHIP_RESET_OUT(crst),
        .RESET_PIN_OUT(pin_o), .RESET_PIN_OE_OUT(pin_oe));
    cpu_bus_model cpu (.clk_in(clk), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
        .rd_out(rd));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // ====
    // reference model, one step per bus clock
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            {chain, por, rdq} = {32'd0, 32'd0, -32'd1};
            {ovf, tck, oie, tie, to_due, irq_m, irq_m1, wake_m} = '0;
            rate = 2'h3;
            dog = 3'h0;
        end else if (live) begin
            rdq = -1;
            if (por < 4064) begin
                por++;
                chain = (por == 4064) ? 0 : chain + 1;
            end else begin
                if (rd) begin
                    rdq = (addr == COUNT_ADDR) ? (chain >> 2) & 255 :
                        (addr == STATUS_CONTROL_ADDR) ? {ovf, tck, oie, tie, 4'(rate)} : 0;
                end
                hit_o = (chain & 1023) == 1023;
                hit_t = (chain & ((2048 << rate) - 1)) == (2048 << rate) - 1;
                if (wr && addr == STATUS_CONTROL_ADDR) begin
                    ovf = ovf && !wdata[3];
                    tck = tck && !wdata[2];
                    {oie, tie, rate} = {wdata[5:4], wdata[1:0]};
                end
                ovf = ovf || hit_o;
                tck = tck || hit_t;
                // timeout looks at the old stage; a refresh beats a tick in the count
                if (hit_t && dog == 3'h7) {to_due, live} = 2'b10;
                else if (wr && addr == WATCHDOG_ADDR && !wdata[0]) dog = 3'h0;
                else if (hit_t) dog++;
                chain = (chain + 1) & 16383;
                wake_m = wait_x && irq_m;
                irq_m1 = irq_m;
                irq_m = (ovf && oie) || (tck && tie);
            end
        end
    end
    // every result compared half a cycle after it settles
    always @(negedge clk) if (live && rst_b) begin
        chk(8'(crst), 8'(por < 4064));
        chk(rdata, (rdq >= 0) ? rdq[7:0] : 8'h00);
        chk(8'(irq), 8'(irq_m1));
        chk(8'(wake), 8'(wake_m));
        chk(8'(pin_oe), 8'h00);
    end
    task automatic do_reset();
        rst_b <= 1'b0;
        ext_hi <= 1'b1;
        repeat (20) @(posedge clk);
        live = 1'b1;
        rst_b <= 1'b1;
        repeat (4100) @(posedge clk);
    endtask
    task automatic traffic(input int n);
        for (int i = 0; i < n && live; i++) begin
            case ($urandom % 6)
                0: cpu.cycle(1'b0, STATUS_CONTROL_ADDR, 8'h00);
                1: cpu.cycle(1'b0, COUNT_ADDR, 8'h00);
                2: cpu.set_ctl(8'($urandom));
                3: cpu.cycle(1'b1, WATCHDOG_ADDR, 8'($urandom));
                4: cpu.cycle(1'($urandom), 16'($urandom), 8'($urandom));
                default: repeat (1 + $urandom % 300) @(posedge clk); // never zero
            endcase
            wait_x <= 1'($urandom);
        end
    endtask
    task automatic finish_test();
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        finish_test();
    end
    // ====
    // scenarios
    initial begin
        void'($urandom(64414));
        do_reset();
        traffic(300);
        do_reset();
        cpu.set_ctl(8'h20); // fastest tap, overflow enabled
        for (k = 0; k < 20000 && live; k++) @(posedge clk);
        chk(8'(to_due), 8'h01);
        @(negedge clk);
        if (!pin_oe) @(negedge clk);
        chk(8'(pin_oe), 8'h01);
        chk(8'(crst), 8'h01);
        do_reset();
        cpu.set_ctl(8'h23);
        wait_x <= 1'b1;
        repeat (1100) @(negedge clk);
        chk(8'(wake), 8'h01);
        cpu.set_ctl(8'h0b);
        traffic(20);
        live = 1'b0;
        ext_hi <= 1'b0;
        repeat (2) @(negedge clk);
        chk(8'(crst), 8'h01);
        do_reset();
        live = 1'b0;
        stop_x <= 1'b1;
        @(posedge clk);
        stop_x <= 1'b0;
        @(negedge clk);
        chk(8'(crst), 8'h01);
        finish_test();
    end
endmodule
